// ===== smbi_core.sv
// Static memory bus controller for areas 4 to 6 with card mode
module smbi_core (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_req_valid,
   input wire smbi_pkg::smbi_req_t i_req,
   input wire smbi_pkg::smbi_cfg_t i_cfg,
   input wire logic [31:0] i_data,
   input wire logic i_wait_n,
   output logic o_ready,
   output logic o_ack,
   output logic o_err,
   output logic [127:0] o_rdata,
   output smbi_pkg::smbi_pins_t o_pins
);
   import smbi_pkg::*;

   smbi_state_t state, next_state; // Bus sequencer
   smbi_area_t area, next_area; // Area of the transfer in flight
   logic card, next_card; // Card mode for this transfer
   logic io_space, next_io_space; // Card I/O half
   logic write, next_write;
   logic line, next_line;
   logic ign, next_ign; // Wait input ignored
   logic err, next_err; // Unmapped address
   logic extending, next_extending; // Wait stretched by the pin
   logic [1:0] wlog, next_wlog; // Device width as log2 bytes
   logic [2:0] alog, next_alog; // Access size as log2 bytes
   logic [5:0] waits, next_waits; // Software waits per beat
   logic [5:0] cnt, next_cnt; // Setup, wait and hold counter
   logic [2:0] hold, next_hold;
   logic [4:0] beats, next_beats; // Beats left, this one included
   logic [31:0] baddr, next_baddr; // Address of the current beat
   logic [127:0] wbuf, next_wbuf;
   logic [127:0] rbuf, next_rbuf;
   logic ready, next_ready;
   logic ack, next_ack;
   smbi_pins_t pins, next_pins;
   logic wait_on; // Wait pin reads asserted
   logic sample_en; // Wait pin honoured for this transfer
   logic [5:0] wrun; // Helper: wait cycles in this beat

   // Byte lanes of one beat
   function automatic logic [3:0] lanes_of(input logic [1:0] wl, input logic [2:0] al,
                                           input logic [1:0] a);
      logic [1:0] ab;
      logic [3:0] base;
      logic [1:0] sh;
      ab = (al < {1'b0, wl}) ? al[1:0] : wl;
      base = (ab == 2'h0) ? 4'h1 : (ab == 2'h1) ? 4'h3 : 4'hF;
      sh = a & ((wl == 2'h0) ? 2'h0 : (wl == 2'h1) ? 2'h1 : 2'h3);
      return 4'(base << sh);
   endfunction

   // Width field to log2 bytes, longword refused in card mode
   function automatic logic [1:0] width_log(input logic hi, input logic lo, input logic cm);
      logic [1:0] w;
      w = ({hi, lo} == WIDTH_BYTE) ? 2'h0 : ({hi, lo} == WIDTH_WORD) ? 2'h1 : 2'h2;
      if (cm && w == 2'h2) begin
         w = 2'h1;
      end
      return w;
   endfunction

   smbi_wait_smp u_wait (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_wait_n(i_wait_n),
      .i_late_sel(i_cfg.hold_sample_edge_sel),
      .i_extending(extending),
      .o_wait_on(wait_on)
   );

   // Pin honoured only with software waits and outside the ignore cases
   assign sample_en = (waits != 6'h0) && !ign;

   // Sequencer and transfer context
   always_comb begin
      logic [3:0] off;
      logic [2:0] al;
      logic [1:0] wl;
      off = 4'h0;
      al = 3'h0;
      wl = 2'h0;
      next_state = state;
      next_area = area;
      next_card = card;
      next_io_space = io_space;
      next_write = write;
      next_line = line;
      next_ign = ign;
      next_err = err;
      next_extending = extending;
      next_wlog = wlog;
      next_alog = alog;
      next_waits = waits;
      next_cnt = cnt;
      next_hold = hold;
      next_beats = beats;
      next_baddr = baddr;
      next_wbuf = wbuf;
      next_rbuf = rbuf;
      case (state)
         ST_IDLE: begin
            if (i_req_valid) begin
               next_write = i_req.write;
               next_line = i_req.line;
               next_wbuf = i_req.wdata;
               next_ign = (i_req.src != SRC_CPU);
               next_baddr = i_req.line ? {i_req.addr[31:4], 4'h0} : i_req.addr;
               next_io_space = i_req.addr[CARD_IO_BIT];
               next_err = 1'b0;
               next_extending = 1'b0;
               next_rbuf = 128'h0;
               next_hold = 3'h0;
               next_card = 1'b0;
               al = i_req.line ? LINE_LOG : {1'b0, i_req.size};
               case (i_req.addr[AREA_MSB:AREA_LSB]) // Bits 31:29 ignored
                  AREA4_CODE: begin
                     next_area = AR_4;
                     wl = width_log(i_cfg.area4_width_hi, i_cfg.area4_width_lo, 1'b0);
                     next_waits = WAIT_TABLE[{1'b0, i_cfg.area4_wait_field}];
                     next_cnt = 6'h0;
                  end
                  AREA5_CODE: begin
                     next_area = AR_5;
                     next_card = i_cfg.area5_card_mode;
                     wl = width_log(i_cfg.area5_width_hi, i_cfg.area5_width_lo,
                                    i_cfg.area5_card_mode);
                     next_waits = WAIT_TABLE[{i_cfg.area5_card_wait_msb & i_cfg.area5_card_mode,
                                              i_cfg.area5_wait_field}];
                     next_cnt = {3'h0, i_cfg.area5_setup_field};
                     next_hold = i_cfg.area5_hold_field;
                  end
                  AREA6_CODE: begin
                     next_area = AR_6;
                     next_card = i_cfg.area6_card_mode;
                     wl = width_log(i_cfg.area6_width_hi, i_cfg.area6_width_lo,
                                    i_cfg.area6_card_mode);
                     next_waits = WAIT_TABLE[{i_cfg.area6_card_wait_msb & i_cfg.area6_card_mode,
                                              i_cfg.area6_wait_field}];
                     next_cnt = {3'h0, i_cfg.area6_setup_field};
                     next_hold = i_cfg.area6_hold_field;
                  end
                  default: begin // Not ours: answer with an error, no pin activity
                     next_area = AR_NONE;
                     next_err = 1'b1;
                     next_cnt = 6'h0;
                  end
               endcase
               next_wlog = wl;
               next_alog = al;
               // Narrow device splits the access; a line always moves 16 bytes
               next_beats = (al > {1'b0, wl}) ? 5'(5'h1 << (al - {1'b0, wl})) : 5'h1;
               if (next_err) begin
                  next_state = ST_GAP;
               end else if (next_cnt != 6'h0) begin
                  next_state = ST_SETUP;
               end else begin
                  next_state = ST_FIRST;
               end
            end
         end
         ST_SETUP: begin // Select ahead of the strobes
            next_cnt = cnt - 6'h1;
            if (cnt == 6'h1) begin
               next_state = ST_FIRST;
            end
         end
         ST_FIRST: begin
            next_extending = 1'b0;
            next_cnt = waits;
            next_state = (waits == 6'h0) ? ST_SECOND : ST_WAIT;
         end
         ST_WAIT: begin
            if (cnt != 6'h1) begin
               next_cnt = cnt - 6'h1;
            end else if (sample_en && wait_on) begin
               next_extending = 1'b1;
            end else begin
               next_state = ST_SECOND;
            end
         end
         ST_SECOND: begin
            // Capture the full device width at the beat's aligned offset
            off = baddr[3:0] & ~4'((4'h1 << wlog) - 4'h1);
            if (!write) begin
               for (int i = 0; i < 4; i++) begin
                  if (i < (1 << wlog)) begin
                     next_rbuf[8 * (4'(off + 4'(i))) +: 8] = i_data[8 * i +: 8];
                  end
               end
            end
            if (beats != 5'h1) begin
               // Next beat follows with no release, pitch two plus waits
               next_beats = beats - 5'h1;
               next_baddr = baddr + 32'(6'h1 << wlog);
               next_state = ST_FIRST;
            end else if (hold != 3'h0) begin
               next_cnt = {3'h0, hold};
               next_state = ST_HOLD;
            end else begin
               next_state = ST_GAP;
            end
         end
         ST_HOLD: begin // Select kept after the strobes
            next_cnt = cnt - 6'h1;
            if (cnt == 6'h1) begin
               next_state = ST_GAP;
            end
         end
         ST_GAP: begin // Select negated before the next access
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Pins, answer and ready, all from next values so outputs are flops
   always_comb begin
      logic [3:0] off;
      logic strobe;
      off = next_baddr[3:0] & ~4'((4'h1 << next_wlog) - 4'h1);
      strobe = (next_state == ST_FIRST) || (next_state == ST_WAIT) || (next_state == ST_SECOND);
      next_pins = PINS_IDLE;
      next_ready = (next_state == ST_IDLE);
      next_ack = (next_state == ST_GAP) && (state != ST_GAP);
      if (strobe || next_state == ST_SETUP || next_state == ST_HOLD) begin
         next_pins.addr = next_baddr[25:0];
         next_pins.area4_select_n = !(next_area == AR_4);
         next_pins.area5_select_n = !(next_area == AR_5 && !next_card);
         next_pins.area6_select_n = !(next_area == AR_6 && !next_card);
         next_pins.card_a_enable_low_n = !(next_area == AR_5 && next_card);
         next_pins.card_a_enable_high_n = !(next_area == AR_5 && next_card);
         next_pins.card_b_enable_low_n = !(next_area == AR_6 && next_card);
         next_pins.card_b_enable_high_n = !(next_area == AR_6 && next_card);
         if (next_write) begin
            next_pins.data_oe_n = 1'b0;
            next_pins.wdata = 32'(next_wbuf >> {off, 3'h0});
         end
      end
      if (strobe) begin
         next_pins.bus_cycle_start_n = !(next_state == ST_FIRST);
         if (next_area == AR_6 && next_card && next_io_space) begin
            next_pins.card_io_read_n = next_write;
            next_pins.card_io_write_n = !next_write;
         end else if (!next_write) begin
            next_pins.read_n = 1'b0;
         end else if (next_card) begin
            next_pins.byte_write_strobes_n = ~CARD_WE_LANES;
         end else begin
            next_pins.byte_write_strobes_n = ~lanes_of(next_wlog, next_alog,
                                                       next_baddr[1:0]);
         end
      end
   end

   // Registers; low clock enable freezes everything
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state <= ST_IDLE;
         area <= AR_NONE;
         card <= 1'b0;
         io_space <= 1'b0;
         write <= 1'b0;
         line <= 1'b0;
         ign <= 1'b0;
         err <= 1'b0;
         extending <= 1'b0;
         wlog <= 2'h0;
         alog <= 3'h0;
         waits <= 6'h0;
         cnt <= 6'h0;
         hold <= 3'h0;
         beats <= 5'h0;
         baddr <= 32'h0;
         wbuf <= 128'h0;
         rbuf <= 128'h0;
         ready <= 1'b0;
         ack <= 1'b0;
         pins <= PINS_IDLE;
      end else if (i_ce) begin
         state <= next_state;
         area <= next_area;
         card <= next_card;
         io_space <= next_io_space;
         write <= next_write;
         line <= next_line;
         ign <= next_ign;
         err <= next_err;
         extending <= next_extending;
         wlog <= next_wlog;
         alog <= next_alog;
         waits <= next_waits;
         cnt <= next_cnt;
         hold <= next_hold;
         beats <= next_beats;
         baddr <= next_baddr;
         wbuf <= next_wbuf;
         rbuf <= next_rbuf;
         ready <= next_ready;
         ack <= next_ack;
         pins <= next_pins;
      end
   end

   assign o_ready = ready;
   assign o_ack = ack;
   assign o_err = err;
   assign o_rdata = rbuf;
   assign o_pins = pins;

   // Helper: wait cycles spent in the current beat
   always_ff @(posedge i_clk) begin
      if (i_reset || state == ST_FIRST) begin
         wrun <= 6'h0;
      end else if (i_ce && state == ST_WAIT) begin
         wrun <= wrun + 6'h1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset || !i_ce);

   a_start_one_cycle: assert property (!o_pins.bus_cycle_start_n |=> o_pins.bus_cycle_start_n)
      else $error("bus start strobe longer than one cycle");
   a_nowait_two: assert property (state == ST_FIRST && waits == 6'h0 |=> state == ST_SECOND)
      else $error("no-wait beat not two cycles");
   a_wait_exact: assert property (state == ST_WAIT && next_state == ST_SECOND && !extending
      |-> wrun + 6'h1 == waits)
      else $error("wrong number of software waits");
   a_wait_stretch: assert property (state == ST_WAIT && cnt == 6'h1 && sample_en && wait_on
      |=> state == ST_WAIT)
      else $error("asserted wait did not stretch the cycle");
   a_wait_ignored: assert property (ign |-> !extending)
      else $error("wait input honoured when it must be ignored");
   a_area4_select: assert property (state == ST_FIRST && area == AR_4 |-> !o_pins.area4_select_n
      && o_pins.area5_select_n && o_pins.area6_select_n)
      else $error("area 4 select wrong");
   a_gap_negated: assert property (state == ST_GAP |-> o_pins.area4_select_n
      && o_pins.area5_select_n && o_pins.area6_select_n)
      else $error("select held through the gap");
   a_card_strobe: assert property (state == ST_FIRST && card && area == AR_5 && write
      |-> o_pins.byte_write_strobes_n == ~CARD_WE_LANES)
      else $error("card write strobe wrong");
   a_card_width: assert property (state != ST_IDLE && card |-> wlog != 2'h2)
      else $error("longword width in card mode");
   a_read_no_we: assert property (state == ST_SECOND && !write
      |-> o_pins.byte_write_strobes_n == 4'hF && !(o_pins.read_n && o_pins.card_io_read_n))
      else $error("read drove write strobes");
   a_line_beats: assert property (state == ST_IDLE && next_state != ST_IDLE && i_req.line
      && !next_err |=> beats == 5'(5'h10 >> wlog))
      else $error("line transfer not 16 bytes");

   c_area4_read: cover property (state == ST_FIRST && area == AR_4 && !write);
   c_card_io: cover property (state == ST_FIRST && area == AR_6 && card && io_space);
   c_stretched: cover property (extending && state == ST_SECOND);
   c_line_fill: cover property (line && !write && beats == 5'h4 && state == ST_SECOND);
endmodule

// ===== smbi_pkg.sv
// Package of types and constants for the static memory bus interface of areas 4 to 6
// Summary of operation
// - Area 4 when address bits 28:26 are 100
// - Area 4 drives select, read, byte writes
// - Area 4 wait field gives 0-10 waits
// - Areas 5, 6 decode 101, 110, shadows ignored
// - Area 5 card: whole area memory, no I/O half
// - Area 6 card: low half memory, high I/O
// - Card mode allows only byte or word width
// - Area 5: select or card A enables, WE1
// - Area 6: select or card B, I/O strobes
// - Areas 5, 6 waits 0-10, card 0-38
// - External wait input may stretch a cycle that has software waits
// - Burst pitch follows waits: 2-12, card 2-40
// - Areas 5, 6 programmable setup and hold
// - No-wait access takes two clock cycles
// - Bus start strobe low exactly one cycle
// - Select negates leaving a gap between accesses
// - Reads full width, non-card writes strobe written bytes
// - Line transfers move 16 bytes without release
// - Nonzero wait field inserts exactly its decoded number of waits
// - Wait input sampled only leaving last wait
// - Late-edge select re-samples an unreliable wait
// - Wait input ignored for DMA and write-back cases
package smbi_pkg;
   localparam logic [2:0] AREA4_CODE = 3'h4; // Address bits 28:26
   localparam logic [2:0] AREA5_CODE = 3'h5;
   localparam logic [2:0] AREA6_CODE = 3'h6;
   localparam int AREA_MSB = 28; // Top decoded bit, bits above are shadows
   localparam int AREA_LSB = 26;
   localparam int CARD_IO_BIT = 25; // Upper 32 Mbytes of a card area
   localparam logic [1:0] WIDTH_BYTE = 2'h1; // Width field codes
   localparam logic [1:0] WIDTH_WORD = 2'h2;
   localparam logic [2:0] LINE_LOG = 3'h4; // 16-byte cache line
   localparam logic [1:0] SIZE_BYTE = 2'h0; // Access size codes
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;
   localparam logic [3:0] CARD_WE_LANES = 4'h2; // Card writes use strobe 1 only
   // Wait field decode, index is {card msb, field}
   localparam logic [5:0] WAIT_TABLE [0:15] = '{
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h0A,
      6'h0C, 6'h0E, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22, 6'h26};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_FIRST = 3'b010, ST_WAIT = 3'b011,
      ST_SECOND = 3'b100, ST_HOLD = 3'b101, ST_GAP = 3'b110
   } smbi_state_t;

   typedef enum logic [1:0] {
      AR_NONE = 2'b00, AR_4 = 2'b01, AR_5 = 2'b10, AR_6 = 2'b11
   } smbi_area_t;

   // Requester kinds; all but the processor ignore the wait input
   typedef enum logic [1:0] {
      SRC_CPU = 2'b00, SRC_WRITEBACK = 2'b01, SRC_DMA_DUAL16 = 2'b10, SRC_DMA_SINGLE16 = 2'b11
   } smbi_src_t;

   typedef struct packed {
      logic [31:0] addr; // Physical start address
      logic [127:0] wdata; // Byte i of the line on bits 8i+7:8i
      logic [1:0] size; // Ignored for line transfers
      logic write;
      logic line; // Cache fill or write-back of 16 bytes
      smbi_src_t src;
   } smbi_req_t;

   typedef struct packed {
      logic area4_width_hi;
      logic area4_width_lo;
      logic area5_width_hi;
      logic area5_width_lo;
      logic area6_width_hi;
      logic area6_width_lo;
      logic [2:0] area4_wait_field;
      logic [2:0] area5_wait_field;
      logic [2:0] area6_wait_field;
      logic area5_card_wait_msb;
      logic area6_card_wait_msb;
      logic [2:0] area5_setup_field;
      logic [2:0] area5_hold_field;
      logic [2:0] area6_setup_field;
      logic [2:0] area6_hold_field;
      logic area5_card_mode;
      logic area6_card_mode;
      logic hold_sample_edge_sel;
   } smbi_cfg_t;

   typedef struct packed {
      logic [25:0] addr;
      logic [31:0] wdata;
      logic data_oe_n; // Low while the data pins are driven
      logic area4_select_n;
      logic area5_select_n;
      logic area6_select_n;
      logic card_a_enable_low_n;
      logic card_a_enable_high_n;
      logic card_b_enable_low_n;
      logic card_b_enable_high_n;
      logic read_n;
      logic [3:0] byte_write_strobes_n;
      logic card_io_read_n;
      logic card_io_write_n;
      logic bus_cycle_start_n;
   } smbi_pins_t;

   localparam smbi_pins_t PINS_IDLE = '{addr: 26'h0, wdata: 32'h0, byte_write_strobes_n: 4'hF,
      default: 1'b1};
endpackage

// ===== smbi_wait_smp.sv
// Sampler for the external wait input
module smbi_wait_smp (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_wait_n,
   input wire logic i_late_sel,
   input wire logic i_extending,
   output logic o_wait_on
);
   import smbi_pkg::*;

   logic prev_on; // Previous sample, kept only while a wait is being stretched
   logic next_prev_on;

   // Previous sample tracking
   always_comb begin
      next_prev_on = i_extending & ~i_wait_n;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         prev_on <= 1'b0;
      end else if (i_ce) begin
         prev_on <= next_prev_on;
      end
   end

   // Late edge needs two clean negated samples before release
   always_comb begin
      if (i_late_sel) begin
         o_wait_on = ~i_wait_n | prev_on;
      end else begin
         o_wait_on = ~i_wait_n;
      end
   end
endmodule

// ===== smbi_sram_model.sv
// Behavioural static RAM and card socket facing the bus interface
module smbi_sram_model
   import smbi_pkg::*;
(
   input wire logic i_clk,
   input wire smbi_pkg::smbi_pins_t i_pins,
   input wire logic [7:0] i_stall,
   output logic [31:0] o_data,
   output logic o_wait_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:63]; // Word store, upper address bits alias
   logic [31:0] last = 32'h0; // Last value put on the data pins
   logic [7:0] cnt = 8'h00; // Wait cycles still to be held
   logic rd; // A read strobe is active
   logic sel; // Some select or low card enable is active
   assign rd = !i_pins.read_n || !i_pins.card_io_read_n;
   assign sel = !(i_pins.area4_select_n && i_pins.area5_select_n && i_pins.area6_select_n &&
      i_pins.card_a_enable_low_n && i_pins.card_b_enable_low_n);
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 32'hA5000000 | i;
   end
   // Released pins show the inverse of the last value, never a stale match
   assign o_data = rd ? mem[i_pins.addr[7:2]] : ~last;
   assign o_wait_n = (cnt == 8'h00);
   // Storage, and the stretch requested by the bench after each bus start
   always @(posedge i_clk) begin
      if (rd) last <= mem[i_pins.addr[7:2]];
      if (!i_pins.bus_cycle_start_n) cnt <= i_stall;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      for (int k = 0; k < 4; k++) begin
         if (sel && !i_pins.byte_write_strobes_n[k])
            mem[i_pins.addr[7:2]][8*k+:8] <= i_pins.wdata[8*k+:8];
      end
   end
endmodule

// ===== smbi_testbench.sv
// Self-checking bench for the static memory bus interface
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import smbi_pkg::*;
   logic i_clk = 0, i_reset = 1, i_req_valid = 0, o_ready, o_ack, o_err, wait_n;
   smbi_req_t req = '0; // Request under way
   smbi_cfg_t cfg = '0; // Longword widths, no waits
   logic [31:0] data; // Read pins from the model
   logic [127:0] o_rdata;
   smbi_pins_t pins;
   logic [7:0] stall = 8'h00; // Wait-pin stretch asked of the model
   logic [9:0] seen; // Strobes seen low during one access
   logic [3:0] we_seen; // Byte write lanes seen low
   logic oe_seen; // Data pins driven at some point of the access
   int num_errors = 0, n_compared = 0, cyc, starts, ticks = 0;
   always #5 i_clk = ~i_clk;
   smbi_core smbi_core_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
      .i_req_valid(i_req_valid), .i_req(req), .i_cfg(cfg), .i_data(data), .i_wait_n(wait_n),
      .o_ready(o_ready), .o_ack(o_ack), .o_err(o_err), .o_rdata(o_rdata), .o_pins(pins));
   smbi_sram_model smbi_sram_model_i (.i_clk(i_clk), .i_pins(pins), .i_stall(stall),
      .o_data(data), .o_wait_n(wait_n));
   // Verdict and end of run, reached from the sequence or the hang guard
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard, far above the longest expected sequence
   always @(posedge i_clk) begin
      ticks++;
      if (ticks == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   // One transfer: present at a falling edge, count cycles from take to acknowledge
   task automatic run(input logic [31:0] a, input logic [1:0] sz, input logic wr,
      input smbi_src_t s, input logic ln, input logic [127:0] w, input logic [7:0] st);
      while (!o_ready) @(negedge i_clk);
      req = '{addr: a, wdata: w, size: sz, write: wr, line: ln, src: s};
      stall = st;
      i_req_valid = 1;
      @(posedge i_clk);
      @(negedge i_clk);
      i_req_valid = 0;
      {cyc, starts, seen, we_seen, oe_seen} = '0;
      while (1) begin
         seen |= ~{pins.area4_select_n, pins.area5_select_n, pins.area6_select_n,
            pins.card_a_enable_low_n, pins.card_a_enable_high_n, pins.card_b_enable_low_n,
            pins.card_b_enable_high_n, pins.read_n, pins.card_io_read_n, pins.card_io_write_n};
         we_seen |= ~pins.byte_write_strobes_n;
         oe_seen |= ~pins.data_oe_n;
         if (!pins.bus_cycle_start_n) starts++;
         if (o_ack || cyc > 300) break;
         @(negedge i_clk);
         cyc++;
      end
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      i_reset = 0;
      // Shadow read of area 4, no waits
      run(32'h30000004, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h00);
      chk(cyc, 2, "cycles");
      chk(starts, 1, "starts");
      chk(seen, 10'h204, "area4 pins");
      chk(o_rdata[63:32], 32'hA5000001, "read");
      run(32'h10000006, SIZE_BYTE, 1, SRC_CPU, 0, 128'h3C << 48, 8'h00);
      chk(we_seen, 4'h4, "byte lane");
      chk(oe_seen, 1'b1, "data drive");
      run(32'h10000004, SIZE_BYTE, 0, SRC_CPU, 0, '0, 8'h00);
      chk(oe_seen, 1'b0, "read no drive");
      chk(o_rdata[63:32], 32'hA53C0001, "full width read");
      // Every software wait code of area 4
      for (int c = 0; c < 8; c++) begin
         cfg.area4_wait_field = c[2:0];
         run(32'h10000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h00);
         chk(cyc, 2 + WAIT_TABLE[c], "sw waits");
      end
      cfg.area4_wait_field = 3'h1;
      run(32'h10000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h03);
      chk(cyc, 6, "pin waits");
      // Late-edge sampling needs two negated samples after a stretch
      cfg.hold_sample_edge_sel = 1;
      run(32'h10000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h03);
      chk(cyc, 7, "late sample");
      cfg.hold_sample_edge_sel = 0;
      run(32'h10000000, SIZE_LONG, 1, SRC_DMA_DUAL16, 0, '0, 8'h03);
      chk(cyc, 3, "pin ignored");
      cfg.area4_wait_field = 3'h0;
      run(32'h10000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h03);
      chk(cyc, 2, "no sw wait");
      // Line fill at longword and word width
      run(32'h10000010, SIZE_BYTE, 0, SRC_CPU, 1, '0, 8'h00);
      chk(starts, 4, "line beats");
      chk(o_rdata, {32'hA5000007, 32'hA5000006, 32'hA5000005, 32'hA5000004}, "line");
      cfg.area4_width_hi = 1;
      run(32'h10000010, SIZE_LONG, 0, SRC_CPU, 1, '0, 8'h00);
      chk(starts, 8, "word beats");
      // Areas 5 and 6 as ordinary memory, setup and hold
      run(32'h14000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h00);
      chk(seen, 10'h104, "area5 pins");
      run(32'hF8000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h00);
      chk(seen, 10'h084, "area6 pins");
      {cfg.area5_setup_field, cfg.area5_hold_field} = {3'h2, 3'h1};
      run(32'h14000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h00);
      chk(cyc, 5, "setup hold");
      // Card mode
      {cfg.area5_card_mode, cfg.area6_card_mode, cfg.area5_setup_field} = {2'h3, 3'h0};
      cfg.area5_hold_field = 3'h0;
      run(32'h14000002, SIZE_BYTE, 1, SRC_CPU, 0, '0, 8'h00);
      chk(seen, 10'h060, "card a");
      chk(we_seen, 4'h2, "card strobe");
      run(32'h1A000000, SIZE_WORD, 0, SRC_CPU, 0, '0, 8'h00);
      chk(seen, 10'h01A, "card io");
      run(32'h18000000, SIZE_WORD, 0, SRC_CPU, 0, '0, 8'h00);
      chk(seen, 10'h01C, "card mem");
      {cfg.area5_card_wait_msb, cfg.area5_wait_field} = {1'b1, 3'h7};
      run(32'h16000000, SIZE_WORD, 0, SRC_CPU, 0, '0, 8'h00);
      chk(cyc, 40, "card waits");
      run(32'h00000000, SIZE_LONG, 0, SRC_CPU, 0, '0, 8'h00);
      chk({o_err, seen}, 11'h400, "unmapped");
      wrap_up();
   end
endmodule
